// ==== rtl/pts_defs.svh ====
// Register map, field positions, reset values and timing counts of the pulse train sequencer
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH

// Register indices; the byte address on the bus is four times the index
`define PTS_IDX_MODE      10'h000
`define PTS_IDX_PERIOD    10'h004
`define PTS_IDX_STATUS    10'h006
`define PTS_IDX_BURST     10'h008
`define PTS_IDX_DURATION  10'h00C
`define PTS_IDX_CTRL      10'h012
`define PTS_IDX_IRQ_STAT  10'h014
`define PTS_IDX_IRQ_CLR   10'h015
`define PTS_IDX_IRQ_EN    10'h016
`define PTS_IDX_BASE      10'h017

`define PTS_ADDR_PERIOD   (`PTS_IDX_PERIOD   << 2)
`define PTS_ADDR_STATUS   (`PTS_IDX_STATUS   << 2)
`define PTS_ADDR_BURST    (`PTS_IDX_BURST    << 2)
`define PTS_ADDR_DURATION (`PTS_IDX_DURATION << 2)
`define PTS_ADDR_CTRL     (`PTS_IDX_CTRL     << 2)
`define PTS_ADDR_IRQ_STAT (`PTS_IDX_IRQ_STAT << 2)
`define PTS_ADDR_IRQ_CLR  (`PTS_IDX_IRQ_CLR  << 2)
`define PTS_ADDR_IRQ_EN   (`PTS_IDX_IRQ_EN   << 2)
`define PTS_ADDR_BASE     (`PTS_IDX_BASE     << 2)

// Control register fields
`define PTS_CTRL_BURST    0
`define PTS_CTRL_IRQ      1
`define PTS_CTRL_START    8
`define PTS_CTRL_STOP     9
`define PTS_CTRL_NEW      10
`define PTS_CTRL_RST      16'h0000

// Status register fields
`define PTS_STAT_BURST    0
`define PTS_STAT_RUN      1
`define PTS_STAT_IRQ      2

// Interrupt status bits
`define PTS_EV_SET_DONE   0
`define PTS_EV_EXHAUSTED  1

// Base time unit: 1000 ns at a 100 ns clock
`define PTS_CLK_NS        100
`define PTS_BASE_NS       1000
`define PTS_BASE_RST      16'((`PTS_BASE_NS + `PTS_CLK_NS - 1) / `PTS_CLK_NS)

`endif

// ==== rtl/pts_pkg.sv ====
// Types shared by the pulse train sequencer modules
package pts_pkg;

    typedef enum logic {
        PTS_STOPPED = 1'b0,
        PTS_RUNNING = 1'b1
    } pts_run_type;

    typedef struct packed {
        logic        burst_en;
        logic [22:0] period;
        logic [22:0] duration;
        logic [22:0] burst;
    } pts_set_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [9:0] addr;
    } pts_ahb_req_type;

    typedef struct packed {
        pts_run_type     run;
        pts_set_type     active;
        pts_set_type     staged;
        pts_set_type     pending;
        logic            pend_valid;
        logic            irq_en;
        logic [22:0]     cnt;
        logic [22:0]     pulses;
        logic [1:0]      irq_stat;
        logic [1:0]      irq_mask;
        logic [15:0]     base;
        pts_ahb_req_type dph;
        logic [31:0]     rdata;
        logic            out;
        logic            irq;
        logic            ready;
    } pts_core_type;

    typedef struct packed {
        logic [1:0] prev;
    } pts_rise_type;

    typedef struct packed {
        logic [15:0] cnt;
    } pts_tick_type;

endpackage : pts_pkg

// ==== rtl/pts_tick.sv ====
// Base time divider: one-cycle enable pulse every div clock cycles
`timescale 1ns/1ns
module pts_tick
    import pts_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        en,
    input  wire logic        clr,
    input  wire logic [15:0] div,
    output logic             tick
);
    pts_tick_type r_reg;
    pts_tick_type r_next;
    logic         last;

    // A divisor of zero behaves as one so the engine never stalls
    assign last = (17'(r_reg.cnt) + 17'h00001) >= 17'(div);
    assign tick = en && !clr && last;

    always_comb begin
        r_next = r_reg;
        if (clr || !en || last) begin
            r_next.cnt = 16'h0000;
        end else begin
            r_next.cnt = r_reg.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule : pts_tick

// ==== rtl/pts_rise.sv ====
// Rising edge finder for written control bits, compared with the last written value
`timescale 1ns/1ns
module pts_rise
    import pts_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       strobe,
    input  wire logic [1:0] din,
    output logic      [1:0] rise
);
    pts_rise_type r_reg;
    pts_rise_type r_next;

    assign rise = strobe ? (din & ~r_reg.prev) : 2'h0;

    always_comb begin
        r_next = r_reg;
        if (strobe) begin
            r_next.prev = din;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule : pts_rise

// ==== rtl/pts_sequencer.sv ====
// Pulse train burst sequencer with its AHB-Lite register slave
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ns
`include "pts_defs.svh"
module pts_sequencer
    import pts_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic      [31:0] HRDATA,
    output logic             HRESP,
    output logic             PULSE_OUT,
    output logic             IRQ
);
    pts_core_type r_reg;
    pts_core_type r_next;

    logic        ctrl_wr;
    logic [1:0]  ctrl_rise;
    logic        start_rise;
    logic        stop_rise;
    logic        commit;
    logic        defer;
    logic        tick;
    logic        running;
    logic        wrap;
    logic        burst_mode;
    logic        set_done;
    logic        addr_ok;
    pts_set_type new_set;

    assign running    = (r_reg.run == PTS_RUNNING);
    assign ctrl_wr    = r_reg.dph.wr && (r_reg.dph.addr == 10'(`PTS_ADDR_CTRL));
    assign start_rise = ctrl_rise[0];
    assign stop_rise  = ctrl_rise[1];
    assign commit     = ctrl_wr && HWDATA[`PTS_CTRL_NEW];
    assign burst_mode = r_reg.active.burst_en && (r_reg.active.burst != 23'h000000);
    // A set is deferred only behind a burst that is actually counting
    assign defer      = running && burst_mode;
    assign wrap       = running && tick
                        && ((24'(r_reg.cnt) + 24'h000001) >= 24'(r_reg.active.period));
    assign set_done   = wrap && burst_mode
                        && ((r_reg.pulses + 23'h000001) == r_reg.active.burst);
    assign addr_ok    = (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'h0);

    // The mode bit travels with the commit write, the rest from staged values
    always_comb begin
        new_set          = r_reg.staged;
        new_set.burst_en = HWDATA[`PTS_CTRL_BURST];
    end

    pts_rise u_rise (
        .clk    (CLK),
        .resetn (RESETN),
        .strobe (ctrl_wr),
        .din    (HWDATA[`PTS_CTRL_STOP:`PTS_CTRL_START]),
        .rise   (ctrl_rise)
    );

    pts_tick u_tick (
        .clk    (CLK),
        .resetn (RESETN),
        .en     (running),
        .clr    (start_rise),
        .div    (r_reg.base),
        .tick   (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        r_next       = r_reg;
        r_next.ready = 1'h1;

        // Address phase capture; reads are answered without wait states
        r_next.dph   = '0;
        r_next.rdata = 32'h00000000;
        if (HSEL && HREADY && HTRANS[1] && addr_ok) begin
            r_next.dph.wr   = HWRITE;
            r_next.dph.rd   = !HWRITE;
            r_next.dph.addr = HADDR[9:0];
            if (!HWRITE) begin
                if (HADDR[9:0] == 10'(`PTS_ADDR_PERIOD)) begin
                    r_next.rdata = {9'h000, r_reg.active.period};
                end else if (HADDR[9:0] == 10'(`PTS_ADDR_DURATION)) begin
                    r_next.rdata = {9'h000, r_reg.active.duration};
                end else if (HADDR[9:0] == 10'(`PTS_ADDR_BURST)) begin
                    r_next.rdata = {9'h000, r_reg.active.burst};
                end else if (HADDR[9:0] == 10'(`PTS_ADDR_STATUS)) begin
                    r_next.rdata[`PTS_STAT_BURST] = r_reg.active.burst_en;
                    r_next.rdata[`PTS_STAT_RUN]   = running;
                    r_next.rdata[`PTS_STAT_IRQ]   = r_reg.irq_en;
                end else if (HADDR[9:0] == 10'(`PTS_ADDR_IRQ_STAT)) begin
                    r_next.rdata = {30'h00000000, r_reg.irq_stat};
                end else if (HADDR[9:0] == 10'(`PTS_ADDR_IRQ_EN)) begin
                    r_next.rdata = {30'h00000000, r_reg.irq_mask};
                end else if (HADDR[9:0] == 10'(`PTS_ADDR_BASE)) begin
                    r_next.rdata = {16'h0000, r_reg.base};
                end
                // Control and clear registers are write-only and read zero
            end
        end

        // Data phase writes of the staged values and local registers
        if (r_reg.dph.wr) begin
            if (r_reg.dph.addr == 10'(`PTS_ADDR_PERIOD)) begin
                r_next.staged.period = HWDATA[22:0];
            end else if (r_reg.dph.addr == 10'(`PTS_ADDR_DURATION)) begin
                r_next.staged.duration = HWDATA[22:0];
            end else if (r_reg.dph.addr == 10'(`PTS_ADDR_BURST)) begin
                r_next.staged.burst = HWDATA[22:0];
            end else if (r_reg.dph.addr == 10'(`PTS_ADDR_IRQ_EN)) begin
                r_next.irq_mask = HWDATA[1:0];
            end else if (r_reg.dph.addr == 10'(`PTS_ADDR_BASE)) begin
                r_next.base = HWDATA[15:0];
            end
        end
        if (ctrl_wr) begin
            r_next.irq_en = HWDATA[`PTS_CTRL_IRQ];
        end

        // Pulse engine, advanced on the base time enable
        if (wrap) begin
            r_next.cnt = 23'h000000;
            if (burst_mode) begin
                r_next.pulses = r_reg.pulses + 23'h000001;
            end
        end else if (running && tick) begin
            r_next.cnt = r_reg.cnt + 23'h000001;
        end

        // End of a set: chain the pending set or stop on the spot
        if (set_done) begin
            r_next.pulses = 23'h000000;
            if (r_reg.pend_valid) begin
                r_next.active     = r_reg.pending;
                r_next.pend_valid = 1'h0;
            end else begin
                r_next.run = PTS_STOPPED;
            end
        end

        // A commit after an end of set in the same cycle refills pending
        if (commit) begin
            if (defer) begin
                r_next.pending    = new_set;
                r_next.pend_valid = 1'h1;
            end else begin
                r_next.active     = new_set;
                r_next.pend_valid = 1'h0;
                r_next.cnt        = 23'h000000;
                r_next.pulses     = 23'h000000;
            end
        end

        // Start while stopped begins the period from its beginning; halt wins over start
        if (start_rise && !running) begin
            r_next.run    = PTS_RUNNING;
            r_next.cnt    = 23'h000000;
            r_next.pulses = 23'h000000;
        end
        if (stop_rise) begin
            r_next.run        = PTS_STOPPED;
            r_next.cnt        = 23'h000000;
            r_next.pulses     = 23'h000000;
            r_next.pend_valid = 1'h0;
        end

        // Sticky events: a set in the clearing cycle survives the clear
        if (r_reg.dph.wr && (r_reg.dph.addr == 10'(`PTS_ADDR_IRQ_CLR))) begin
            r_next.irq_stat = r_reg.irq_stat & ~HWDATA[1:0];
        end
        if (set_done && r_reg.irq_en) begin
            r_next.irq_stat[`PTS_EV_SET_DONE] = 1'h1;
        end
        if (set_done && !r_reg.pend_valid && !(commit && defer)) begin
            r_next.irq_stat[`PTS_EV_EXHAUSTED] = 1'h1;
        end
        // A commit landing on the end of set still chains, so it must not stop
        if (set_done && !r_reg.pend_valid && commit && defer) begin
            r_next.active     = new_set;
            r_next.pend_valid = 1'h0;
            r_next.run        = stop_rise ? PTS_STOPPED : PTS_RUNNING;
        end

        r_next.out = (r_next.run == PTS_RUNNING)
                     && (r_next.cnt < r_next.active.duration);
        r_next.irq = |(r_next.irq_stat & r_next.irq_mask);
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            r_reg      <= '0;
            r_reg.base <= `PTS_BASE_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign HREADYOUT = r_reg.ready;
    assign HRDATA    = r_reg.rdata;
    assign HRESP     = 1'h0;
    assign PULSE_OUT = r_reg.out;
    assign IRQ       = r_reg.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    ctrl_reads_zero_a: assert property (
        (HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == 32'(`PTS_ADDR_CTRL))
        |=> (HRDATA == 32'h00000000))
        else $error("control register did not read as zero");

    start_edge_a: assert property (
        (ctrl_wr && HWDATA[`PTS_CTRL_START] && !HWDATA[`PTS_CTRL_STOP]
         && !u_rise.r_reg.prev[0] && !running)
        |=> (r_reg.run == PTS_RUNNING) ##0 (r_reg.cnt == 23'h000000))
        else $error("start edge did not start the output");

    halt_edge_a: assert property (
        stop_rise |=> (!running && !PULSE_OUT))
        else $error("halt edge did not stop the output at once");

    stop_is_low_a: assert property (
        !running |-> !PULSE_OUT)
        else $error("output high while stopped");

    exhaust_stop_a: assert property (
        (set_done && !r_reg.pend_valid && !commit && !start_rise)
        |=> (!running && !PULSE_OUT))
        else $error("output did not stop at burst exhaustion");

    chain_set_a: assert property (
        (set_done && r_reg.pend_valid && !stop_rise && !commit)
        |=> running && (r_reg.active == $past(r_reg.pending))
            && (r_reg.pulses == 23'h000000) && !r_reg.pend_valid)
        else $error("pending set not taken at end of burst");

    done_event_a: assert property (
        (set_done && r_reg.irq_en) |=> r_reg.irq_stat[`PTS_EV_SET_DONE])
        else $error("end of burst event lost");

    quiet_event_a: assert property (
        (!set_done && !r_reg.irq_stat[`PTS_EV_SET_DONE])
        |=> !r_reg.irq_stat[`PTS_EV_SET_DONE])
        else $error("end of burst event raised without cause");

    commit_now_a: assert property (
        (commit && !defer && !stop_rise) |=> (r_reg.active == $past(new_set)))
        else $error("immediate commit not applied");

    commit_later_a: assert property (
        (commit && defer && !set_done && !stop_rise)
        |=> r_reg.pend_valid && $stable(r_reg.active))
        else $error("deferred commit disturbed the running set");

    period_read_a: assert property (
        (HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == 32'(`PTS_ADDR_PERIOD))
        |=> (HRDATA == {9'h000, $past(r_reg.active.period)}))
        else $error("period read did not return the active value");

    duration_read_a: assert property (
        (HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == 32'(`PTS_ADDR_DURATION))
        |=> (HRDATA == {9'h000, $past(r_reg.active.duration)}))
        else $error("duration read did not return the active value");

    burst_read_a: assert property (
        (HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == 32'(`PTS_ADDR_BURST))
        |=> (HRDATA == {9'h000, $past(r_reg.active.burst)}))
        else $error("burst read did not return the active value");

    status_read_a: assert property (
        (HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR == 32'(`PTS_ADDR_STATUS))
        |=> (HRDATA[`PTS_STAT_RUN] == $past(running)))
        else $error("status read did not show the running flag");

    mode_bit_a: assert property (
        (commit && !defer) |=> (r_reg.active.burst_en == $past(HWDATA[`PTS_CTRL_BURST])))
        else $error("mode bit not taken with the committed set");

    irq_allow_a: assert property (
        ctrl_wr |=> (r_reg.irq_en == $past(HWDATA[`PTS_CTRL_IRQ])))
        else $error("interrupt allow bit not stored");

    no_start_a: assert property (
        (ctrl_wr && !(HWDATA[`PTS_CTRL_START] && !u_rise.r_reg.prev[0]) && !running)
        |=> !running)
        else $error("output started without a start edge");

    commit_bit_a: assert property (
        (ctrl_wr && !HWDATA[`PTS_CTRL_NEW] && !set_done) |=> $stable(r_reg.active))
        else $error("active set changed without a commit");

    set_irq_a: assert property (
        (set_done && r_reg.pend_valid && r_reg.irq_en)
        |=> r_reg.irq_stat[`PTS_EV_SET_DONE] && (r_reg.active == $past(r_reg.pending)))
        else $error("chained set did not raise its event");

    exhaust_event_a: assert property (
        (set_done && !r_reg.pend_valid && !commit)
        |=> r_reg.irq_stat[`PTS_EV_EXHAUSTED])
        else $error("exhaustion event lost");

    pulse_shape_a: assert property (
        PULSE_OUT == (running && (r_reg.cnt < r_reg.active.duration)))
        else $error("output level disagrees with the period counter");

    irq_level_a: assert property (
        IRQ == (|(r_reg.irq_stat & r_reg.irq_mask)))
        else $error("interrupt level disagrees with enabled events");

    halt_drop_a: assert property (
        stop_rise |=> !r_reg.pend_valid)
        else $error("halt kept a pending set");

endmodule : pts_sequencer

// ==== dv/pulse_train_burst_sequencer_test.sv ====
// Self-checking register bus testbench of the pulse train burst sequencer
`timescale 1ns/1ns
`include "pts_defs.svh"
module pulse_train_burst_sequencer_test
    import pts_pkg::*;
;
    localparam logic [31:0] A_PER   = 32'(`PTS_ADDR_PERIOD);
    localparam logic [31:0] A_STAT  = 32'(`PTS_ADDR_STATUS);
    localparam logic [31:0] A_BUR   = 32'(`PTS_ADDR_BURST);
    localparam logic [31:0] A_DUR   = 32'(`PTS_ADDR_DURATION);
    localparam logic [31:0] A_CTRL  = 32'(`PTS_ADDR_CTRL);
    localparam logic [31:0] A_ISTAT = 32'(`PTS_ADDR_IRQ_STAT);
    localparam logic [31:0] A_ICLR  = 32'(`PTS_ADDR_IRQ_CLR);
    localparam logic [31:0] A_IEN   = 32'(`PTS_ADDR_IRQ_EN);
    localparam logic [31:0] A_BASE  = 32'(`PTS_ADDR_BASE);
    localparam logic [31:0] A_NONE  = 32'h0000_0040;

    logic        clk;
    logic        resetn;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        pulse_out;
    logic        irq;
    int          n_mismatch;
    int          comparisons;
    int          cycles;
    int          highs;

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    pts_sequencer dut (
        .CLK       (clk),
        .RESETN    (resetn),
        .HSEL      (1'b1),
        .HADDR     (haddr),
        .HTRANS    (htrans),
        .HWRITE    (hwrite),
        .HSIZE     (3'b010),
        .HWDATA    (hwdata),
        .HREADY    (hreadyout),
        .HREADYOUT (hreadyout),
        .HRDATA    (hrdata),
        .HRESP     (hresp),
        .PULSE_OUT (pulse_out),
        .IRQ       (irq)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit

    // One single transfer; the master waits on hready and never assumes a latency
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1)
            @(posedge clk);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk_word(q, exp);
    endtask : rdc

    // Reads until the masked field matches; the retry bound keeps a dead design from hanging
    task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] v);
        int          n;
        logic [31:0] q;
        n = 0;
        bus(1'b0, a, 32'h0000_0000, q);
        while ((q & m) !== v && n < 500) begin
            n++;
            bus(1'b0, a, 32'h0000_0000, q);
        end
        chk_word(q & m, v);
    endtask : poll

    // With the base divisor at one, any window of whole periods holds exactly duration high cycles per period
    task automatic count_high(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(posedge clk);
            if (pulse_out === 1'b1)
                h++;
        end
    endtask : count_high

    task automatic set_params(input logic [31:0] p, input logic [31:0] d, input logic [31:0] b);
        wr(A_PER, p);
        wr(A_DUR, d);
        wr(A_BUR, b);
    endtask : set_params

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        resetn      = 1'b0;
        haddr       = 32'h0000_0000;
        htrans      = 2'b00;
        hwrite      = 1'b0;
        hwdata      = 32'h0000_0000;
        n_mismatch  = 0;
        comparisons = 0;
        cycles      = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Reset state, write-only control and an unmapped place
        rdc(A_CTRL, 32'h0000_0000);
        rdc(A_STAT, 32'h0000_0000);
        rdc(A_ISTAT, 32'h0000_0000);
        chk_bit(pulse_out, 1'b0);
        chk_bit(irq, 1'b0);
        chk_bit(hresp, 1'b0);
        wr(A_NONE, 32'h0000_FFFF);
        rdc(A_NONE, 32'h0000_0000);
        wr(A_BASE, 32'h0000_0001);
        rdc(A_BASE, 32'h0000_0001);
        // Continuous mode: commit while stopped applies at once, then start
        set_params(32'h0000_0008, 32'h0000_0003, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0400);
        rdc(A_PER, 32'h0000_0008);
        wr(A_CTRL, 32'h0000_0500);
        rdc(A_STAT, 32'h0000_0002);
        count_high(40, highs);
        chk_word(32'(highs), 32'h0000_000F);
        // Commit while running continuous takes effect at once
        set_params(32'h0000_0006, 32'h0000_0001, 32'h0000_0000);
        rdc(A_PER, 32'h0000_0008);
        wr(A_CTRL, 32'h0000_0400);
        rdc(A_PER, 32'h0000_0006);
        rdc(A_DUR, 32'h0000_0001);
        repeat (4) @(posedge clk);
        count_high(36, highs);
        chk_word(32'(highs), 32'h0000_0006);
        // Halt edge stops at once; a write without a start edge keeps it stopped
        wr(A_CTRL, 32'h0000_0300);
        rdc(A_STAT, 32'h0000_0000);
        count_high(20, highs);
        chk_word(32'(highs), 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0100);
        rdc(A_STAT, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_0000);
        // Burst without the interrupt allow bit: exhaustion stops, no set-done event
        wr(A_IEN, 32'h0000_0003);
        set_params(32'h0000_0004, 32'h0000_0001, 32'h0000_0002);
        wr(A_CTRL, 32'h0000_0501);
        poll(A_STAT, 32'h0000_0002, 32'h0000_0000);
        rdc(A_ISTAT, 32'h0000_0002);
        chk_bit(pulse_out, 1'b0);
        wr(A_ICLR, 32'h0000_0003);
        rdc(A_ISTAT, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        wr(A_CTRL, 32'h0000_0000);
        // Burst sequence: second set chains, then the run exhausts
        set_params(32'h0000_0004, 32'h0000_0001, 32'h0000_0014);
        wr(A_CTRL, 32'h0000_0503);
        rdc(A_STAT, 32'h0000_0007);
        set_params(32'h0000_0005, 32'h0000_0002, 32'h0000_0003);
        wr(A_CTRL, 32'h0000_0403);
        rdc(A_PER, 32'h0000_0004);
        rdc(A_BUR, 32'h0000_0014);
        poll(A_PER, 32'hFFFF_FFFF, 32'h0000_0005);
        rdc(A_STAT, 32'h0000_0007);
        rdc(A_ISTAT, 32'h0000_0001);
        chk_bit(irq, 1'b1);
        poll(A_STAT, 32'h0000_0002, 32'h0000_0000);
        rdc(A_ISTAT, 32'h0000_0003);
        chk_bit(pulse_out, 1'b0);
        // Interrupt masking and clearing
        wr(A_IEN, 32'h0000_0000);
        @(posedge clk);
        chk_bit(irq, 1'b0);
        wr(A_IEN, 32'h0000_0002);
        @(posedge clk);
        chk_bit(irq, 1'b1);
        wr(A_ICLR, 32'h0000_0003);
        @(posedge clk);
        chk_bit(irq, 1'b0);
        rdc(A_ISTAT, 32'h0000_0000);
        test_done();
    end

endmodule : pulse_train_burst_sequencer_test
